// ---- port2_mux_pkg.sv ----
// Shared constants for the port 2 routing and OTG interface block
package port2_mux_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PULL = 8'h04;
  localparam logic [7:0] OFF_MON = 8'h08;
  localparam logic [7:0] OFF_INT_STATUS = 8'h0c;
  localparam logic [7:0] OFF_INT_MASK = 8'h10;
  // Control register fields
  localparam int CTRL_SE_SEL_LSB = 0;
  localparam int CTRL_HOST_SEL = 2;
  localparam int CTRL_SUSPEND = 3;
  localparam int CTRL_SPEED = 4;
  localparam int CTRL_VBUS_EN = 5;
  localparam int CTRL_VBUS_PULSE = 6;
  localparam int CTRL_ID_DRIVE = 7;
  localparam int CTRL_WIDTH = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] PULL_RESET = 6'h00;
  localparam int PULL_WIDTH = 6;
  localparam int MON_WIDTH = 6;
  localparam int INT_WIDTH = 3;
  localparam int INT_XCVR = 0;
  localparam int INT_SRP = 1;
  localparam int INT_ID = 2;
  // Single-ended select codes
  localparam logic [1:0] SE_ONCHIP = 2'h0;
  localparam logic [1:0] SE_EXT_OTG = 2'h1;
  localparam logic [1:0] SE_NONOTG_2 = 2'h2;
  localparam logic [1:0] SE_NONOTG_3 = 2'h3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Line states from the external transceiver
  typedef enum logic [1:0] {
    LINE_SE0 = 2'b00,
    LINE_LOW_SPEED = 2'b01,
    LINE_FULL_SPEED = 2'b10,
    LINE_ERROR = 2'b11
  } line_state_t;
endpackage

// ---- usb_port2_otg_interface_mux.sv ----
// Port 2 routing, OTG switch control and external transceiver interface
// Behaviour
// (R1) Sleep entry clears every register, so earlier bus state is forgotten; the code clears only control, pull, mask, status, switch and pad registers.
// (R2) Host on port 2: host data switch on both lines, other switches off.
// (R3) Device on port 2: pull switch A on D+ only, host switch off.
// (R4) Device mode: switch B hardware-driven during idle or upstream receive only.
// (R5) Mux device or host 2 to on-chip transceiver; device/host2/host3 to pins.
// (R6) External OTG mode: select picks device or host signals for pads.
// (R7) External OTG: software suspend and speed outputs, interrupt input accepted.
// (R8) Charge pump mode: host-select bit picks device or host for on-chip transceiver.
// (R9) Two software outputs to charge pump: Vbus drive and Vbus pulsing.
// (R10) Accept two Vbus-valid inputs, session valid, and session request interrupt.
// (R11) ID sense enable drives ID pin weakly high; input read back.
// (R12) ID interrupt flags any change of the sensed ID level.
// (R13) Select value 2 or 3 chooses non-OTG external transceiver mode.
// (R14) Non-OTG mode: pins one-directional, transceiver carries D+ and D-.
// (R15) Output pair: both low logic 0, A only logic 1, B high SE0.
// (R16) Input pair: 00 SE0, B only low speed, A only full speed, 11 error.
// (R17) Separate pull-up and pull-down enables per line, each its own bit.
// (R18) Controls change on the clock and return disabled on reset.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module usb_port2_otg_interface_mux
  import port2_mux_pkg::*;
(
  // Clock, reset, sleep entry
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sleep_entry,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device controller single-ended port
  input wire logic dev_dp,
  input wire logic dev_dm,
  input wire logic dev_oe_n,
  input wire logic dev_idle_rx,
  output logic dev_rx_dp,
  output logic dev_rx_dm,
  // Host controller ports 2 and 3
  input wire logic host2_dp,
  input wire logic host2_dm,
  input wire logic host2_oe_n,
  input wire logic host3_dp,
  input wire logic host3_dm,
  input wire logic host3_oe_n,
  output logic host_rx_dp,
  output logic host_rx_dm,
  // On-chip transceiver data and switches
  output logic xcvr_dp,
  output logic xcvr_dm,
  output logic xcvr_oe_n,
  input wire logic xcvr_rx_dp,
  input wire logic xcvr_rx_dm,
  output logic [1:0] pull_switch_a,
  output logic [1:0] pull_switch_b,
  output logic [1:0] host_data_switch,
  output logic dplus_pullup_enable,
  output logic dminus_pullup_enable,
  output logic dplus_pullup_b_enable,
  output logic dminus_pullup_b_enable,
  output logic dplus_pulldown_enable,
  output logic dminus_pulldown_enable,
  // Single-ended GPIO pins
  output logic port2_out_line_a,
  output logic port2_out_line_b,
  output logic port2_oe_n,
  input wire logic port2_in_line_a,
  input wire logic port2_in_line_b,
  output logic [1:0] ext_line_state,
  // External transceiver and charge pump
  output logic ext_xcvr_suspend_out,
  output logic ext_xcvr_speed_out,
  input wire logic ext_xcvr_irq,
  output logic pump_vbus_enable,
  output logic pump_vbus_pulse_enable,
  input wire logic vbus_valid_40,
  input wire logic vbus_valid_44,
  input wire logic session_valid,
  input wire logic srp_detect_irq,
  // OTG ID pin (weak drive)
  input wire logic id_in,
  output logic id_out,
  output logic id_oe_n,
  // Interrupt
  output logic irq
);

  logic [CTRL_WIDTH-1:0] ctrl;
  logic [PULL_WIDTH-1:0] pull;
  logic [INT_WIDTH-1:0] int_status;
  logic [INT_WIDTH-1:0] int_mask;
  logic [1:0] se_sel;
  logic ext_otg_mode;
  logic nonotg_mode;
  logic onchip_host;
  logic clear_all;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] next_rdata;
  logic rd_map;
  logic wr_map;
  logic status_read;
  logic [8:0] sync_a;
  logic [8:0] sync_b;
  logic [8:0] pin_in;
  logic id_prev;
  logic id_seen;
  logic [INT_WIDTH-1:0] evt_prev;
  logic [INT_WIDTH-1:0] events;

  // Sleep entry acts as a synchronous clear of the control, pull and mask registers, interrupt status and switch and pad outputs
  assign clear_all = sleep_entry; // R1

  // Two-flop synchronisers on every pin input
  assign pin_in = {port2_in_line_a, port2_in_line_b, ext_xcvr_irq, vbus_valid_40, vbus_valid_44,
                   session_valid, srp_detect_irq, id_in, 1'b0};
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  // Mode decode from the single-ended select field
  assign se_sel = ctrl[CTRL_SE_SEL_LSB +: 2];
  assign ext_otg_mode = (se_sel == SE_EXT_OTG);
  assign nonotg_mode = (se_sel == SE_NONOTG_2) || (se_sel == SE_NONOTG_3); // R13
  assign onchip_host = ctrl[CTRL_HOST_SEL];

  // Transceiver data path and switch settings, registered so outputs move on the clock
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xcvr_dp <= 1'b0;
      xcvr_dm <= 1'b0;
      xcvr_oe_n <= 1'b1;
      pull_switch_a <= 2'b00;
      pull_switch_b <= 2'b00;
      host_data_switch <= 2'b00;
    end
    else if (clear_all || se_sel != SE_ONCHIP)
    begin
      xcvr_dp <= 1'b0; // R18
      xcvr_dm <= 1'b0;
      xcvr_oe_n <= 1'b1;
      pull_switch_a <= 2'b00;
      pull_switch_b <= 2'b00;
      host_data_switch <= 2'b00;
    end
    else if (onchip_host)
    begin
      xcvr_dp <= host2_dp; // R5 R8
      xcvr_dm <= host2_dm;
      xcvr_oe_n <= host2_oe_n;
      host_data_switch <= 2'b11; // R2
      pull_switch_a <= 2'b00;
      pull_switch_b <= 2'b00;
    end
    else
    begin
      xcvr_dp <= dev_dp; // R5 R8
      xcvr_dm <= dev_dm;
      xcvr_oe_n <= dev_oe_n;
      host_data_switch <= 2'b00; // R3
      pull_switch_a <= 2'b01; // R3
      // Bit 0 is D+; D- stays off
      pull_switch_b <= {1'b0, dev_idle_rx & dev_oe_n}; // R4
    end
  end

  // GPIO pad routing; in non-OTG mode host port 3 may take over via select value 3
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port2_out_line_a <= 1'b0;
      port2_out_line_b <= 1'b0;
      port2_oe_n <= 1'b1;
    end
    else if (clear_all || se_sel == SE_ONCHIP)
    begin
      port2_out_line_a <= 1'b0;
      port2_out_line_b <= 1'b0;
      port2_oe_n <= 1'b1;
    end
    else if (nonotg_mode && se_sel == SE_NONOTG_3)
    begin
      // SE0 shows as line B high whatever line A holds
      port2_out_line_a <= host3_dp; // R5 R14 R15
      port2_out_line_b <= ~host3_dp & ~host3_dm;
      port2_oe_n <= host3_oe_n;
    end
    else if (onchip_host)
    begin
      port2_out_line_a <= host2_dp; // R6 R15
      port2_out_line_b <= ~host2_dp & ~host2_dm;
      port2_oe_n <= host2_oe_n;
    end
    else
    begin
      port2_out_line_a <= dev_dp; // R6 R15
      port2_out_line_b <= ~dev_dp & ~dev_dm;
      port2_oe_n <= dev_oe_n;
    end
  end

  // Receive path back to the controllers: on-chip transceiver in on-chip mode, otherwise decoded from the input pair
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_line_state <= LINE_SE0;
      dev_rx_dp <= 1'b0;
      dev_rx_dm <= 1'b0;
      host_rx_dp <= 1'b0;
      host_rx_dm <= 1'b0;
    end
    else
    begin
      ext_line_state <= {sync_b[8], sync_b[7]}; // R16
      if (se_sel == SE_ONCHIP)
      begin
        dev_rx_dp <= xcvr_rx_dp;
        dev_rx_dm <= xcvr_rx_dm;
        host_rx_dp <= xcvr_rx_dp;
        host_rx_dm <= xcvr_rx_dm;
      end
      else
      begin
        // Full speed drives D+, low speed drives D-; SE0 and error give both low
        dev_rx_dp <= sync_b[8] & ~sync_b[7]; // R16 R14
        dev_rx_dm <= sync_b[7] & ~sync_b[8];
        host_rx_dp <= sync_b[8] & ~sync_b[7];
        host_rx_dm <= sync_b[7] & ~sync_b[8];
      end
    end
  end

  // Software-driven outputs to external parts
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_xcvr_suspend_out <= 1'b0;
      ext_xcvr_speed_out <= 1'b0;
      pump_vbus_enable <= 1'b0;
      pump_vbus_pulse_enable <= 1'b0;
      id_out <= 1'b0;
      id_oe_n <= 1'b1;
      {dplus_pulldown_enable, dminus_pulldown_enable} <= 2'b00;
      {dplus_pullup_b_enable, dminus_pullup_b_enable} <= 2'b00;
      {dplus_pullup_enable, dminus_pullup_enable} <= 2'b00;
    end
    else
    begin
      ext_xcvr_suspend_out <= ctrl[CTRL_SUSPEND]; // R7
      ext_xcvr_speed_out <= ctrl[CTRL_SPEED]; // R7
      pump_vbus_enable <= ctrl[CTRL_VBUS_EN]; // R9
      pump_vbus_pulse_enable <= ctrl[CTRL_VBUS_PULSE]; // R9
      id_out <= ctrl[CTRL_ID_DRIVE]; // R11
      id_oe_n <= ~ctrl[CTRL_ID_DRIVE]; // R11
      {dplus_pullup_enable, dminus_pullup_enable, dplus_pullup_b_enable,
       dminus_pullup_b_enable, dplus_pulldown_enable, dminus_pulldown_enable} <= pull; // R17
    end
  end

  // Edge detection of interrupt sources: rising edges, and any ID change
  assign events = {sync_b[1] ^ id_prev, sync_b[2] & ~evt_prev[INT_SRP], sync_b[6] & ~evt_prev[INT_XCVR]};
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      evt_prev <= 3'h0;
      id_prev <= 1'b0;
      id_seen <= 1'b0;
    end
    else
    begin
      evt_prev <= {1'b0, sync_b[2], sync_b[6]}; // R7 R10
      id_prev <= sync_b[1]; // R12
      id_seen <= 1'b1;
    end
  end

  // Sticky status; a new event wins over the clear-on-read
  assign status_read = rd_fire && s_axi_araddr == OFF_INT_STATUS;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      int_status <= 3'h0;
    else if (clear_all)
      int_status <= 3'h0; // R1
    else
      int_status <= (status_read ? 3'h0 : int_status) | (events & {id_seen, 2'b11}); // R12
  end
  assign irq = |(int_status & int_mask);

  // AXI write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign wr_map = aw_addr == OFF_CTRL || aw_addr == OFF_PULL || aw_addr == OFF_INT_MASK ||
                  aw_addr == OFF_MON || aw_addr == OFF_INT_STATUS;

  // Writable registers, low byte lane only
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl <= CTRL_RESET;
      pull <= PULL_RESET;
      int_mask <= 3'h0;
    end
    else if (clear_all)
    begin
      ctrl <= CTRL_RESET; // R1 R18
      pull <= PULL_RESET;
      int_mask <= 3'h0;
    end
    else if (wr_fire && w_strb[0])
    begin
      if (aw_addr == OFF_CTRL)
        ctrl <= w_data[CTRL_WIDTH-1:0];
      if (aw_addr == OFF_PULL)
        pull <= w_data[PULL_WIDTH-1:0]; // R17
      if (aw_addr == OFF_INT_MASK)
        int_mask <= w_data[INT_WIDTH-1:0];
    end
  end

  // AXI read channel, one cycle to answer
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rd_map = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL: next_rdata[CTRL_WIDTH-1:0] = ctrl;
      OFF_PULL: next_rdata[PULL_WIDTH-1:0] = pull;
      OFF_MON: next_rdata[MON_WIDTH-1:0] = {sync_b[8], sync_b[7], sync_b[5], sync_b[4], sync_b[3], sync_b[1]}; // R10
      OFF_INT_STATUS: next_rdata[INT_WIDTH-1:0] = int_status;
      OFF_INT_MASK: next_rdata[INT_WIDTH-1:0] = int_mask;
      default: rd_map = 1'b0;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks
  a_host_switches: assert property (@(posedge clk) disable iff (!reset_n) // R2
    (se_sel == SE_ONCHIP && onchip_host && !clear_all) |=> (host_data_switch == 2'b11 && pull_switch_a == 2'b00))
    else $error("host switches wrong");
  a_dev_switches: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (se_sel == SE_ONCHIP && !onchip_host && !clear_all) |=> (pull_switch_a == 2'b01 && host_data_switch == 2'b00))
    else $error("device switches wrong");
  a_switch_b_dm: assert property (@(posedge clk) disable iff (!reset_n) // R4
    !pull_switch_b[1] && (!pull_switch_b[0] ||
      $past(dev_idle_rx && dev_oe_n && !onchip_host && se_sel == SE_ONCHIP && !clear_all)))
    else $error("switch b wrong");
  a_sleep_clear: assert property (@(posedge clk) disable iff (!reset_n) // R1
    clear_all |=> (ctrl == CTRL_RESET && int_status == 3'h0))
    else $error("sleep did not clear");
  a_se0_encode: assert property (@(posedge clk) disable iff (!reset_n) // R15
    (se_sel == SE_EXT_OTG && !onchip_host && !clear_all && !dev_dp && !dev_dm) |=> port2_out_line_b)
    else $error("se0 not encoded");
  a_line_decode: assert property (@(posedge clk) disable iff (!reset_n) // R16
    (se_sel != SE_ONCHIP && sync_b[8] && !sync_b[7]) |=> (dev_rx_dp && !dev_rx_dm))
    else $error("full speed decode wrong");
  a_id_drive: assert property (@(posedge clk) disable iff (!reset_n) // R11
    ctrl[CTRL_ID_DRIVE] |=> (id_out && !id_oe_n))
    else $error("id drive wrong");
  a_id_change: assert property (@(posedge clk) disable iff (!reset_n) // R12
    (id_seen && $changed(sync_b[1]) && !clear_all) |=> int_status[INT_ID])
    else $error("id change lost");
  a_pads_off: assert property (@(posedge clk) disable iff (!reset_n) // R5
    (se_sel == SE_ONCHIP) |=> port2_oe_n)
    else $error("pads driven in on-chip mode");
  a_pump_out: assert property (@(posedge clk) disable iff (!reset_n) // R9
    ##1 pump_vbus_enable == $past(ctrl[CTRL_VBUS_EN]))
    else $error("vbus enable mismatch");

endmodule // usb_port2_otg_interface_mux

// ---- ext_xcvr_model.sv ----
// Behavioural external transceiver, charge pump and ID connector model
`timescale 1ns/1ps
module ext_xcvr_model (
  // Scenario controls from the bench
  input wire logic [1:0] line_code,
  input wire logic xirq,
  input wire logic srp,
  input wire logic v40,
  input wire logic v44,
  input wire logic sess,
  input wire logic id_gnd,
  // Pads from the block
  input wire logic out_a,
  input wire logic out_b,
  input wire logic id_out,
  input wire logic id_oe_n,
  // Pads into the block
  output logic in_a,
  output logic in_b,
  output logic x_irq_pin,
  output logic srp_pin,
  output logic v40_pin,
  output logic v44_pin,
  output logic sess_pin,
  output logic id_pin,
  // Line state decoded from the output pair
  output logic [1:0] tx_state
);
  // Receive pair: first pin full speed, second pin low speed
  assign {in_a, in_b} = line_code;
  // Second pin high means SE0 whatever the first pin shows
  assign tx_state = out_b ? 2'h2 : {1'b0, out_a};
  // Interrupt and threshold lines
  assign x_irq_pin = xirq;
  assign srp_pin = srp;
  assign {v40_pin, v44_pin, sess_pin} = {v40, v44, sess};
  // Weak high drive loses to a grounded pin; 100k pull-down wins when undriven
  assign id_pin = ~id_oe_n & id_out & ~id_gnd;
endmodule // ext_xcvr_model

// ---- tb_usb_port2_otg_interface_mux.sv ----
// Self-checking bench for the port 2 routing and OTG interface block
`timescale 1ns/1ps
module tb_usb_port2_otg_interface_mux;
  import port2_mux_pkg::*;
  logic clk, reset_n, sleep_entry, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, rnd;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, sw_a, sw_b, sw_h, ext_ls, line_code, tx_state, src;
  logic [5:0] pulls;
  logic dev_dp, dev_dm, dev_oe_n, idle, dev_rx_dp, dev_rx_dm, h2_dp, h2_dm, h2_oe_n, h3_dp, h3_dm, h3_oe_n;
  logic hrx_dp, hrx_dm, x_dp, x_dm, x_oe_n, xr_dp, xr_dm, out_a, out_b, p2_oe_n, in_a, in_b, susp, spd, v_en, v_pulse;
  logic xirq, srp, v40, v44, sess, id_gnd, x_irq_pin, srp_pin, v40_pin, v44_pin, sess_pin, id_pin, id_out, id_oe_n, irq;
  int bad_count, n_compared;
  line_state_t codes[$] = '{LINE_SE0, LINE_LOW_SPEED, LINE_FULL_SPEED, LINE_ERROR};

  usb_port2_otg_interface_mux DUT (.clk(clk), .reset_n(reset_n), .sleep_entry(sleep_entry),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dev_dp(dev_dp), .dev_dm(dev_dm), .dev_oe_n(dev_oe_n), .dev_idle_rx(idle), .dev_rx_dp(dev_rx_dp),
    .dev_rx_dm(dev_rx_dm), .host2_dp(h2_dp), .host2_dm(h2_dm), .host2_oe_n(h2_oe_n), .host3_dp(h3_dp),
    .host3_dm(h3_dm), .host3_oe_n(h3_oe_n), .host_rx_dp(hrx_dp), .host_rx_dm(hrx_dm), .xcvr_dp(x_dp),
    .xcvr_dm(x_dm), .xcvr_oe_n(x_oe_n), .xcvr_rx_dp(xr_dp), .xcvr_rx_dm(xr_dm), .pull_switch_a(sw_a),
    .pull_switch_b(sw_b), .host_data_switch(sw_h), .dplus_pullup_enable(pulls[5]), .dminus_pullup_enable(pulls[4]),
    .dplus_pullup_b_enable(pulls[3]), .dminus_pullup_b_enable(pulls[2]), .dplus_pulldown_enable(pulls[1]),
    .dminus_pulldown_enable(pulls[0]), .port2_out_line_a(out_a), .port2_out_line_b(out_b), .port2_oe_n(p2_oe_n),
    .port2_in_line_a(in_a), .port2_in_line_b(in_b), .ext_line_state(ext_ls), .ext_xcvr_suspend_out(susp),
    .ext_xcvr_speed_out(spd), .ext_xcvr_irq(x_irq_pin), .pump_vbus_enable(v_en), .pump_vbus_pulse_enable(v_pulse),
    .vbus_valid_40(v40_pin), .vbus_valid_44(v44_pin), .session_valid(sess_pin), .srp_detect_irq(srp_pin),
    .id_in(id_pin), .id_out(id_out), .id_oe_n(id_oe_n), .irq(irq));

  ext_xcvr_model partner (.line_code(line_code), .xirq(xirq), .srp(srp), .v40(v40), .v44(v44), .sess(sess),
    .id_gnd(id_gnd), .out_a(out_a), .out_b(out_b), .id_out(id_out), .id_oe_n(id_oe_n), .in_a(in_a), .in_b(in_b),
    .x_irq_pin(x_irq_pin), .srp_pin(srp_pin), .v40_pin(v40_pin), .v44_pin(v44_pin), .sess_pin(sess_pin),
    .id_pin(id_pin), .tx_state(tx_state));

  // Pseudo-random source, fixed start so runs repeat
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Four-state compare so an unknown never passes
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Long enough for the two sync flops plus output register
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid && t < 50);
    bready <= 1'b0;
    chk("bvalid", 1'b1, bvalid);
    chk("bresp", er, bresp);
  endtask

  // Read: data checked only when an OKAY answer is expected
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && t < 50);
    rready <= 1'b0;
    chk("rresp", er, rresp);
    if (er == RESP_OKAY) chk("rdata", ed, rdata);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is well under a thousand cycles; this is far beyond it
  initial
  begin
    #300000;
    bad_count++;
    close_out();
  end

  initial
  begin
    {reset_n, sleep_entry, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {dev_dp, dev_dm, idle, h2_dp, h2_dm, h3_dp, h3_dm, xr_dp, xr_dm, line_code} = '0;
    {xirq, srp, v40, v44, sess, id_gnd} = '0;
    {dev_oe_n, h2_oe_n, h3_oe_n} = 3'h7;
    wstrb = 4'hf;
    rnd = 8'h04;
    repeat (5) @(posedge clk);
    chk("reset_outs", 32'h0, {sw_a, sw_b, sw_h, pulls, susp, spd, v_en, v_pulse, id_out, irq});
    chk("reset_oe_n", 32'h7, {x_oe_n, p2_oe_n, id_oe_n});
    reset_n <= 1'b1;
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_PULL, 32'h0, RESP_OKAY);
    rd(OFF_INT_MASK, 32'h0, RESP_OKAY);
    // On-chip transceiver: host or device, idle and drive states
    for (int i = 0; i < 8; i++)
    begin
      wr(OFF_CTRL, {29'h0, i[1], 2'h0}, RESP_OKAY);
      rnd = lfsr(rnd);
      {dev_dp, dev_dm, h2_dp, h2_dm, xr_dp, xr_dm} <= rnd[5:0];
      idle <= i[0];
      dev_oe_n <= ~i[2];
      settle();
      chk("sw_host", {2{i[1]}}, sw_h);
      chk("sw_a", i[1] ? 2'h0 : 2'h1, sw_a);
      chk("sw_b", {1'b0, ~i[1] & i[0] & ~i[2]}, sw_b);
      chk("xcvr", i[1] ? {h2_dp, h2_dm, h2_oe_n} : {dev_dp, dev_dm, dev_oe_n}, {x_dp, x_dm, x_oe_n});
      chk("rx_onchip", {xr_dp, xr_dm, xr_dp, xr_dm}, {dev_rx_dp, dev_rx_dm, hrx_dp, hrx_dm});
    end
    // Single-ended pads: external OTG and non-OTG modes
    for (int i = 2; i < 8; i++)
    begin
      wr(OFF_CTRL, {29'h0, i[0], i[2:1]}, RESP_OKAY);
      for (int k = 0; k < 3; k++)
      begin
        rnd = lfsr(rnd);
        {h2_oe_n, h3_oe_n, dev_dp, dev_dm, h2_dp, h2_dm, h3_dp, h3_dm} <= rnd;
        settle();
        src = (i[2:1] == 2'h3) ? {h3_dp, h3_dm} : (i[0] ? {h2_dp, h2_dm} : {dev_dp, dev_dm});
        chk("pad_out", {src[1], ~|src}, {out_a, out_b});
        chk("pad_oe", (i[2:1] == 2'h3) ? h3_oe_n : (i[0] ? h2_oe_n : dev_oe_n), p2_oe_n);
        chk("pad_state", src[1] ? 2'h1 : (src[0] ? 2'h0 : 2'h2), tx_state);
        chk("xcvr_off", 1'b1, x_oe_n);
      end
    end
    // Receive decoding in non-OTG device mode
    wr(OFF_CTRL, 32'h2, RESP_OKAY);
    foreach (codes[j])
    begin
      line_code <= codes[j];
      settle();
      chk("line_state", codes[j], ext_ls);
      chk("dev_rx", {codes[j] == LINE_FULL_SPEED, codes[j] == LINE_LOW_SPEED}, {dev_rx_dp, dev_rx_dm});
      chk("host_rx", {codes[j] == LINE_FULL_SPEED, codes[j] == LINE_LOW_SPEED}, {hrx_dp, hrx_dm});
      rd(OFF_MON, {codes[j], 4'h0}, RESP_OKAY);
    end
    line_code <= LINE_SE0;
    // Software outputs, ending with the ID weak drive on
    for (int b = CTRL_SUSPEND; b <= CTRL_ID_DRIVE; b++)
    begin
      wr(OFF_CTRL, 32'h1 << b, RESP_OKAY);
      settle();
      chk("ctrl_outs", 32'h1 << (b - CTRL_SUSPEND), {id_out, v_pulse, v_en, spd, susp});
    end
    chk("id_drive", 1'b0, id_oe_n);
    rd(OFF_MON, 32'h1, RESP_OKAY);
    id_gnd <= 1'b1;
    settle();
    rd(OFF_MON, 32'h0, RESP_OKAY);
    chk("irq_masked", 1'b0, irq);
    rd(OFF_INT_STATUS, 32'h4, RESP_OKAY);
    rd(OFF_INT_STATUS, 32'h0, RESP_OKAY);
    // Unmasked events raise the level, a status read clears it
    wr(OFF_INT_MASK, 32'h7, RESP_OKAY);
    rd(OFF_INT_MASK, 32'h7, RESP_OKAY);
    for (int b = 0; b < 2; b++)
    begin
      xirq <= (b == 0);
      srp <= (b == 1);
      settle();
      chk("irq", 1'b1, irq);
      rd(OFF_INT_STATUS, 32'h1 << b, RESP_OKAY);
      // Lowered here so the next pass never writes a source twice in one step
      xirq <= 1'b0;
      srp <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq_clear", 1'b0, irq);
    end
    wr(OFF_INT_MASK, 32'h0, RESP_OKAY);
    xirq <= 1'b1;
    settle();
    chk("irq_off", 1'b0, irq);
    rd(OFF_INT_STATUS, 32'h1, RESP_OKAY);
    // Charge pump thresholds and session valid
    {v40, v44, sess} <= 3'h5;
    settle();
    rd(OFF_MON, 32'h0a, RESP_OKAY);
    {v40, v44, sess} <= 3'h2;
    settle();
    rd(OFF_MON, 32'h04, RESP_OKAY);
    // Pull enables, one bit at a time
    for (int b = 0; b < PULL_WIDTH; b++)
    begin
      wr(OFF_PULL, 32'h1 << b, RESP_OKAY);
      settle();
      chk("pulls", 32'h1 << b, pulls);
    end
    // Refused and read-only accesses
    wr(8'h14, 32'h0, RESP_SLVERR);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(OFF_MON, 32'h3f, RESP_OKAY);
    rd(OFF_MON, 32'h04, RESP_OKAY);
    // Sleep entry wipes the control, pull and mask registers
    wr(OFF_CTRL, 32'hfd, RESP_OKAY);
    wr(OFF_INT_MASK, 32'h7, RESP_OKAY);
    sleep_entry <= 1'b1;
    @(posedge clk);
    sleep_entry <= 1'b0;
    settle();
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_PULL, 32'h0, RESP_OKAY);
    rd(OFF_INT_MASK, 32'h0, RESP_OKAY);
    chk("sleep_outs", 32'h0, {pulls, susp, spd, v_en, v_pulse, id_out, irq});
    close_out();
  end
endmodule // tb_usb_port2_otg_interface_mux
